/* msor_pkg.sv */
package msor_pkg;
  localparam int NUM_REGS = 5;
  localparam logic [7:0] OFS_SPEED_DETECT_REVERSE = 8'h23;
  localparam logic [7:0] OFS_OPENLOOP_CURRENT_BRAKE = 8'h24;
  localparam logic [7:0] OFS_STARTUP_ACCELERATION = 8'h25;
  localparam logic [7:0] OFS_LOOP_HANDOVER_ALIGN = 8'h26;
  localparam logic [7:0] OFS_FAULT_SURGE_ENABLE = 8'h27;
  localparam logic [7:0] OPT_BASE = OFS_SPEED_DETECT_REVERSE;
  localparam logic [2:0] IDX_SPEED = 3'h0;
  localparam logic [2:0] IDX_CURRENT = 3'h1;
  localparam logic [2:0] IDX_ACCEL = 3'h2;
  localparam logic [2:0] IDX_HANDOVER = 3'h3;
  localparam logic [2:0] IDX_FAULT = 3'h4;
  localparam logic [7:0] RST_SPEED_DETECT_REVERSE = 8'h00;
  localparam logic [7:0] RST_OPENLOOP_CURRENT_BRAKE = 8'h00;
  localparam logic [7:0] RST_STARTUP_ACCELERATION = 8'h00;
  localparam logic [7:0] RST_LOOP_HANDOVER_ALIGN = 8'h00;
  localparam logic [7:0] RST_FAULT_SURGE_ENABLE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Field positions, most significant bit of each field, plus the least significant bit of the handover field
  localparam int JUDGE_THR_MSB = 7;
  localparam int ADV_ANGLE_MSB = 5;
  localparam int SPEED_DETECT_BIT = 3;
  localparam int REVERSE_EN_BIT = 2;
  localparam int REVERSE_THR_MSB = 1;
  localparam int OL_CURRENT_MSB = 7;
  localparam int OL_RAMP_MSB = 5;
  localparam int BRAKE_TIME_MSB = 2;
  localparam int CTRL_COEF_MSB = 7;
  localparam int ACCEL2_MSB = 5;
  localparam int ACCEL1_MSB = 2;
  localparam int HANDOVER_MSB = 7;
  localparam int HANDOVER_LSB = 3;
  localparam int ALIGN_MSB = 2;
  localparam int NO_MOTOR_BIT = 7;
  localparam int LOCK_EN_MSB = 6;
  localparam int IND_SURGE_BIT = 3;
  localparam int MECH_SURGE_BIT = 2;
  localparam int MECH_MODE_BIT = 1;
  localparam int RELEASE_MODE_BIT = 0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_RX = 3'h2,
    ST_TX = 3'h6,
    ST_MACK = 3'h7
  } msor_state_type;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_prev;
    logic sda_s1;
    logic sda_s2;
    logic sda_prev;
    msor_state_type fsm;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic have_ptr;
    logic rw;
    logic sda_oe;
    logic brake_en;
    logic handover_bad;
    logic [NUM_REGS-1:0][7:0] regs;
  } msor_regs_type;
endpackage : msor_pkg

/* msor_option_regs.sv */
// Behaviour
// - Bits 7:6 of first register pick stationary threshold 6/3/1.6/0.8 Hz.
// - Bits 5:4 pick advance angle 30/60/90/120 degrees after position sensing.
// - Bit 3 of first register enables initial speed detection.
// - Bit 2 of first register enables reverse drive.
// - Bits 1:0 pick reverse or brake start speed 6.3/13/26/51 Hz.
// - Bits 7:6 of second register pick open-loop current 0.2 to 1.6 A.
// - Bits 5:3 pick open-loop current ramp rate, eight steps.
// - Bits 2:0 zero disables braking; others pick halving brake durations.
// - Bits 7:6 of third register pick control coefficient 0.25 to 1.
// - Bits 5:3 pick second-order start acceleration, eight steps.
// - Bits 2:0 pick first-order start acceleration, eight steps.
// - Bits 7:3 of fourth register set handover frequency; code zero invalid.
// - Align time field picks 5.3 s halving down to 0.04 s.
// - Bits 7:4 of fifth register enable four fault detections.
// - Bit 3 of fifth register enables inductive surge protection.
// - Bit 2 of fifth register enables mechanical surge protection.
// - Bit 1 limits surge to supply when 0, to 24 V when 1.
// - Bit 0 brakes on sensing release when 0, high impedance when 1.
`timescale 1ns/1ps
module msor_option_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h52 // Arbitrary bus address
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Two-wire serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Speed detection and reverse options
  output logic [1:0] stationary_judge_threshold,
  output logic [1:0] post_sense_advance_angle,
  output logic initial_speed_detect_enable,
  output logic reverse_drive_enable,
  output logic [1:0] reverse_threshold,
  // Open-loop current and braking
  output logic [1:0] open_loop_current,
  output logic [2:0] open_loop_ramp_rate,
  output logic [2:0] braking_time,
  output logic braking_enable,
  // Start-up acceleration
  output logic [1:0] control_coefficient,
  output logic [2:0] start_accel_second_order,
  output logic [2:0] start_accel_first_order,
  // Loop handover and alignment
  output logic [4:0] loop_handover_threshold,
  output logic handover_code_invalid,
  output logic [2:0] alignment_duration,
  // Fault and surge options
  output logic no_motor_fault_enable,
  output logic [2:0] lock_fault_enables,
  output logic inductive_surge_enable,
  output logic mechanical_surge_enable,
  output logic mechanical_surge_mode,
  output logic sense_release_mode
);
  import msor_pkg::*;

  msor_regs_type s_reg;
  msor_regs_type s_next;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic wr_hit;
  logic [2:0] wr_idx;
  logic tx_load;

  function automatic logic opt_hit(input logic [7:0] p);
    opt_hit = (p >= OPT_BASE) && (p <= OFS_FAULT_SURGE_ENABLE);
  endfunction : opt_hit

  function automatic logic [2:0] opt_index(input logic [7:0] p);
    logic [7:0] d;
    d = p - OPT_BASE;
    opt_index = d[2:0];
  endfunction : opt_index

  always_comb begin
    s_next = s_reg;
    wr_hit = 1'b0;
    wr_idx = opt_index(s_reg.ptr);
    tx_load = 1'b0;
    // Edges come from comparing the second and third stages of each synchroniser
    s_next.scl_s1 = scl_in;
    s_next.scl_s2 = s_reg.scl_s1;
    s_next.scl_prev = s_reg.scl_s2;
    s_next.sda_s1 = sda_in;
    s_next.sda_s2 = s_reg.sda_s1;
    s_next.sda_prev = s_reg.sda_s2;
    scl_rise = s_reg.scl_s2 & ~s_reg.scl_prev;
    scl_fall = ~s_reg.scl_s2 & s_reg.scl_prev;
    bus_start = s_reg.scl_s2 & s_reg.scl_prev & s_reg.sda_prev & ~s_reg.sda_s2;
    bus_stop = s_reg.scl_s2 & s_reg.scl_prev & ~s_reg.sda_prev & s_reg.sda_s2;
    if (bus_start) begin
      s_next.fsm = ST_ADDR;
      s_next.bit_cnt = 4'h0;
      s_next.sda_oe = 1'b0;
      s_next.have_ptr = 1'b0;
    end else if (bus_stop) begin
      s_next.fsm = ST_IDLE;
      s_next.sda_oe = 1'b0;
    end else begin
      unique case (s_reg.fsm)
        ST_IDLE: begin
          s_next.sda_oe = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], s_reg.sda_s2};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end else if (scl_fall && s_reg.bit_cnt == BITS_PER_BYTE) begin
            s_next.fsm = ST_ACK;
            s_next.sda_oe = 1'b1;
            if (s_reg.fsm == ST_ADDR) begin
              // Not our address: stay off the bus until the next start
              if (s_reg.shift[7:1] != DEV_ADDR) begin
                s_next.fsm = ST_IDLE;
                s_next.sda_oe = 1'b0;
              end
              s_next.rw = s_reg.shift[0];
            end else if (!s_reg.have_ptr) begin
              s_next.ptr = s_reg.shift;
              s_next.have_ptr = 1'b1;
            end else begin
              // Writes outside the bank are acknowledged and dropped
              wr_hit = opt_hit(s_reg.ptr);
              if (wr_hit) begin
                s_next.regs[wr_idx] = s_reg.shift;
              end
              s_next.ptr = s_reg.ptr + 8'h01;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            s_next.bit_cnt = 4'h0;
            s_next.sda_oe = 1'b0;
            s_next.fsm = ST_RX;
            // Read byte fetched at the ack fall, ahead of its first bit
            if (s_reg.rw) begin
              tx_load = 1'b1;
              s_next.shift = opt_hit(s_reg.ptr) ? s_reg.regs[wr_idx] : UNMAPPED_READ;
              s_next.sda_oe = ~s_next.shift[7];
              // Pointer wraps at 8 bits; reads past the bank give zeros
              s_next.ptr = s_reg.ptr + 8'h01;
              s_next.fsm = ST_TX;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (s_reg.bit_cnt == BITS_PER_BYTE) begin
              s_next.sda_oe = 1'b0;
              s_next.fsm = ST_MACK;
            end else begin
              s_next.shift = {s_reg.shift[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.shift[6];
            end
          end
        end
        ST_MACK: begin
          // A master acknowledge asks for the next byte
          if (scl_rise) begin
            s_next.fsm = s_reg.sda_s2 ? ST_IDLE : ST_ACK;
          end
        end
        default: begin
          s_next.fsm = ST_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end
    s_next.brake_en = |s_next.regs[IDX_CURRENT][BRAKE_TIME_MSB:0];
    s_next.handover_bad = s_next.regs[IDX_HANDOVER][HANDOVER_MSB:HANDOVER_LSB] == 5'h00;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_prev: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_prev: 1'b1,
                 fsm: ST_IDLE, bit_cnt: 4'h0, shift: 8'h00, ptr: 8'h00, have_ptr: 1'b0, rw: 1'b0,
                 sda_oe: 1'b0, brake_en: 1'b0, handover_bad: 1'b1,
                 regs: {RST_FAULT_SURGE_ENABLE, RST_LOOP_HANDOVER_ALIGN, RST_STARTUP_ACCELERATION,
                        RST_OPENLOOP_CURRENT_BRAKE, RST_SPEED_DETECT_REVERSE}};
    end else begin
      s_reg <= s_next;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = s_reg.sda_oe;
  assign stationary_judge_threshold = s_reg.regs[IDX_SPEED][JUDGE_THR_MSB -: 2];
  assign post_sense_advance_angle = s_reg.regs[IDX_SPEED][ADV_ANGLE_MSB -: 2];
  assign initial_speed_detect_enable = s_reg.regs[IDX_SPEED][SPEED_DETECT_BIT];
  assign reverse_drive_enable = s_reg.regs[IDX_SPEED][REVERSE_EN_BIT];
  assign reverse_threshold = s_reg.regs[IDX_SPEED][REVERSE_THR_MSB -: 2];
  assign open_loop_current = s_reg.regs[IDX_CURRENT][OL_CURRENT_MSB -: 2];
  assign open_loop_ramp_rate = s_reg.regs[IDX_CURRENT][OL_RAMP_MSB -: 3];
  assign braking_time = s_reg.regs[IDX_CURRENT][BRAKE_TIME_MSB -: 3];
  assign braking_enable = s_reg.brake_en;
  assign control_coefficient = s_reg.regs[IDX_ACCEL][CTRL_COEF_MSB -: 2];
  assign start_accel_second_order = s_reg.regs[IDX_ACCEL][ACCEL2_MSB -: 3];
  assign start_accel_first_order = s_reg.regs[IDX_ACCEL][ACCEL1_MSB -: 3];
  assign loop_handover_threshold = s_reg.regs[IDX_HANDOVER][HANDOVER_MSB -: 5];
  assign handover_code_invalid = s_reg.handover_bad;
  assign alignment_duration = s_reg.regs[IDX_HANDOVER][ALIGN_MSB -: 3];
  assign no_motor_fault_enable = s_reg.regs[IDX_FAULT][NO_MOTOR_BIT];
  assign lock_fault_enables = s_reg.regs[IDX_FAULT][LOCK_EN_MSB -: 3];
  assign inductive_surge_enable = s_reg.regs[IDX_FAULT][IND_SURGE_BIT];
  assign mechanical_surge_enable = s_reg.regs[IDX_FAULT][MECH_SURGE_BIT];
  assign mechanical_surge_mode = s_reg.regs[IDX_FAULT][MECH_MODE_BIT];
  assign sense_release_mode = s_reg.regs[IDX_FAULT][RELEASE_MODE_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_judge_thr_write: assert property (wr_hit && wr_idx == IDX_SPEED |=>
    stationary_judge_threshold == $past(s_reg.shift[7:6])) else $error("stationary threshold not written");
  a_speed_detect_write: assert property (wr_hit && wr_idx == IDX_SPEED |=>
    initial_speed_detect_enable == $past(s_reg.shift[3])) else $error("speed detect enable wrong");
  a_reverse_thr_write: assert property (wr_hit && wr_idx == IDX_SPEED |=>
    reverse_threshold == $past(s_reg.shift[1:0])) else $error("reverse threshold wrong");
  a_ol_current_write: assert property (wr_hit && wr_idx == IDX_CURRENT |=>
    open_loop_current == $past(s_reg.shift[7:6])) else $error("open loop current wrong");
  a_brake_enable_code: assert property (wr_hit && wr_idx == IDX_CURRENT |=>
    braking_enable == ($past(s_reg.shift[2:0]) != 3'h0)) else $error("braking enable wrong");
  a_coef_write: assert property (wr_hit && wr_idx == IDX_ACCEL |=>
    control_coefficient == $past(s_reg.shift[7:6])) else $error("control coefficient wrong");
  a_handover_invalid: assert property (wr_hit && wr_idx == IDX_HANDOVER |=>
    handover_code_invalid == ($past(s_reg.shift[7:3]) == 5'h00)) else $error("handover invalid flag wrong");
  a_fault_enable_write: assert property (wr_hit && wr_idx == IDX_FAULT |=>
    {no_motor_fault_enable, lock_fault_enables} == $past(s_reg.shift[7:4])) else $error("fault enables wrong");
  a_release_mode_write: assert property (wr_hit && wr_idx == IDX_FAULT |=>
    sense_release_mode == $past(s_reg.shift[0])) else $error("release mode wrong");
  a_read_back_value: assert property (tx_load && opt_hit(s_reg.ptr) |=>
    s_reg.shift == $past(s_reg.regs[wr_idx]) && s_reg.fsm == ST_TX) else $error("read back differs");
  a_regs_hold: assert property (!wr_hit |=> $stable(s_reg.regs)) else $error("register changed without write");

  // Every field follows the byte written one clock earlier
  a_advance_angle_write: assert property (wr_hit && wr_idx == IDX_SPEED |=>
    post_sense_advance_angle == $past(s_reg.shift[5:4])) else $error("advance angle wrong");
  a_reverse_en_write: assert property (wr_hit && wr_idx == IDX_SPEED |=>
    reverse_drive_enable == $past(s_reg.shift[2])) else $error("reverse drive enable wrong");
  a_ol_ramp_write: assert property (wr_hit && wr_idx == IDX_CURRENT |=>
    open_loop_ramp_rate == $past(s_reg.shift[5:3])) else $error("open loop ramp rate wrong");
  a_accel2_write: assert property (wr_hit && wr_idx == IDX_ACCEL |=>
    start_accel_second_order == $past(s_reg.shift[5:3])) else $error("second order acceleration wrong");
  a_accel1_write: assert property (wr_hit && wr_idx == IDX_ACCEL |=>
    start_accel_first_order == $past(s_reg.shift[2:0])) else $error("first order acceleration wrong");
  a_align_write: assert property (wr_hit && wr_idx == IDX_HANDOVER |=>
    alignment_duration == $past(s_reg.shift[2:0])) else $error("alignment duration wrong");
  a_ind_surge_write: assert property (wr_hit && wr_idx == IDX_FAULT |=>
    inductive_surge_enable == $past(s_reg.shift[3])) else $error("inductive surge enable wrong");
  a_mech_surge_write: assert property (wr_hit && wr_idx == IDX_FAULT |=>
    mechanical_surge_enable == $past(s_reg.shift[2])) else $error("mechanical surge enable wrong");
  a_mech_mode_write: assert property (wr_hit && wr_idx == IDX_FAULT |=>
    mechanical_surge_mode == $past(s_reg.shift[1])) else $error("mechanical surge mode wrong");

  // Derived flags may never drift from the fields they summarise
  a_brake_flag_track: assert property (braking_enable == (braking_time != 3'h0))
    else $error("braking enable drifted");
  a_handover_flag_track: assert property (handover_code_invalid == (loop_handover_threshold == 5'h00))
    else $error("handover invalid flag drifted");
  a_reset_state: assert property ($rose(resetn) |->
    s_reg.regs == {RST_FAULT_SURGE_ENABLE, RST_LOOP_HANDOVER_ALIGN, RST_STARTUP_ACCELERATION,
    RST_OPENLOOP_CURRENT_BRAKE, RST_SPEED_DETECT_REVERSE} && !s_reg.sda_oe) else $error("state after reset wrong");

  // Bus sequencing: acks, address filter, read drive, master nack
  a_start_rearm: assert property (bus_start |=>
    s_reg.fsm == ST_ADDR && s_reg.bit_cnt == 4'h0 && !s_reg.have_ptr) else $error("start did not re-arm");
  a_addr_ack: assert property (s_reg.fsm == ST_ADDR && scl_fall && s_reg.bit_cnt == BITS_PER_BYTE &&
    s_reg.shift[7:1] == DEV_ADDR |=> s_reg.sda_oe && s_reg.rw == $past(s_reg.shift[0]))
    else $error("address not acked");
  a_foreign_addr: assert property (s_reg.fsm == ST_ADDR && scl_fall && s_reg.bit_cnt == BITS_PER_BYTE &&
    s_reg.shift[7:1] != DEV_ADDR |=> s_reg.fsm == ST_IDLE && !s_reg.sda_oe) else $error("foreign address acked");
  a_data_ack: assert property (s_reg.fsm == ST_RX && scl_fall && s_reg.bit_cnt == BITS_PER_BYTE |=>
    s_reg.fsm == ST_ACK && s_reg.sda_oe) else $error("data byte not acked");
  a_ack_release: assert property (s_reg.fsm == ST_ACK && scl_fall && !s_reg.rw |=>
    s_reg.fsm == ST_RX && !s_reg.sda_oe) else $error("ack not released");
  a_oe_states: assert property (s_reg.sda_oe |-> (s_reg.fsm == ST_ACK || s_reg.fsm == ST_TX))
    else $error("data line pulled outside ack or read");
  a_tx_bit_drive: assert property (s_reg.fsm == ST_TX |-> s_reg.sda_oe == ~s_reg.shift[7])
    else $error("read bit driven wrong");
  a_ptr_advance: assert property (wr_hit |=> s_reg.ptr == $past(s_reg.ptr) + 8'h01)
    else $error("pointer did not advance");
  a_unmapped_read: assert property (tx_load && !opt_hit(s_reg.ptr) |=> s_reg.shift == UNMAPPED_READ)
    else $error("unmapped read not zero");
  a_nack_ends_read: assert property (s_reg.fsm == ST_MACK && scl_rise && s_reg.sda_s2 |=> s_reg.fsm == ST_IDLE)
    else $error("read went on after nack");
  a_bit_count_bound: assert property (s_reg.bit_cnt <= BITS_PER_BYTE)
    else $error("bit counter overran");

  c_reg_write: cover property (wr_hit);
  c_reg_read: cover property (tx_load && opt_hit(s_reg.ptr));
  c_unmapped_read: cover property (tx_load && !opt_hit(s_reg.ptr));
  c_burst_read: cover property (s_reg.fsm == ST_MACK ##[1:400] s_reg.fsm == ST_TX);
  c_brake_off: cover property (wr_hit && wr_idx == IDX_CURRENT && s_reg.shift[2:0] == 3'h0);
endmodule : msor_option_regs

/* msor_host_model.sv */
`timescale 1ns/1ps
module msor_host_model (
  // Clock
  input wire logic clk,
  // Bus lines, data as an open-drain pull
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask : pause

  // Also a repeated start when entered with the clock low
  task automatic start_cond();
    pause(4);
    sda_pull <= 1'b0;
    pause(4);
    scl <= 1'b1;
    pause(8);
    sda_pull <= 1'b1;
    pause(8);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    pause(4);
    sda_pull <= 1'b1;
    pause(4);
    scl <= 1'b1;
    pause(8);
    sda_pull <= 1'b0;
    pause(8);
  endtask : stop_cond

  // Data moves 4 clocks after the fall, well clear of the synchroniser delay
  task automatic bit_io(input logic b, output logic r);
    pause(4);
    sda_pull <= ~b;
    pause(4);
    scl <= 1'b1;
    pause(4);
    r = sda;
    pause(4);
    scl <= 1'b0;
  endtask : bit_io

  // Sending 1s releases the line so the device can answer
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(last, nack);
  endtask : xfer
endmodule : msor_host_model

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import msor_pkg::*;
  localparam logic [6:0] ADDR = 7'h52;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, host_pull, dev_oe, dev_out, sda;
  logic initial_speed_detect_enable, reverse_drive_enable, braking_enable, handover_code_invalid;
  logic no_motor_fault_enable, inductive_surge_enable, mechanical_surge_enable, mechanical_surge_mode;
  logic sense_release_mode;
  logic [1:0] stationary_judge_threshold, post_sense_advance_angle, reverse_threshold;
  logic [1:0] open_loop_current, control_coefficient;
  logic [2:0] open_loop_ramp_rate, braking_time, start_accel_second_order, start_accel_first_order;
  logic [2:0] alignment_duration, lock_fault_enables;
  logic [4:0] loop_handover_threshold;
  logic [7:0] b, r;
  logic [7:0] got [0:7];
  logic nack;
  int fail_count = 0;
  int checked = 0;

  always #12.5 clk = ~clk;
  // Pull-up on the data line
  assign sda = ((dev_oe & ~dev_out) | host_pull) ? 1'b0 : 1'b1;

  msor_host_model host (.clk(clk), .scl(scl), .sda_pull(host_pull), .sda(sda));

  msor_option_regs #(.DEV_ADDR(ADDR)) uut (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(dev_out), .sda_oe(dev_oe),
    .stationary_judge_threshold(stationary_judge_threshold), .post_sense_advance_angle(post_sense_advance_angle),
    .initial_speed_detect_enable(initial_speed_detect_enable), .reverse_drive_enable(reverse_drive_enable),
    .reverse_threshold(reverse_threshold), .open_loop_current(open_loop_current),
    .open_loop_ramp_rate(open_loop_ramp_rate), .braking_time(braking_time), .braking_enable(braking_enable),
    .control_coefficient(control_coefficient), .start_accel_second_order(start_accel_second_order),
    .start_accel_first_order(start_accel_first_order), .loop_handover_threshold(loop_handover_threshold),
    .handover_code_invalid(handover_code_invalid), .alignment_duration(alignment_duration),
    .no_motor_fault_enable(no_motor_fault_enable), .lock_fault_enables(lock_fault_enables),
    .inductive_surge_enable(inductive_surge_enable), .mechanical_surge_enable(mechanical_surge_enable),
    .mechanical_surge_mode(mechanical_surge_mode), .sense_release_mode(sense_release_mode));

  task automatic conclude();
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      fail_count++;
    end
  endtask : chk

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // Byte j of the burst carries v ^ j so each register gets its own value
  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] v, input int n);
    logic acc;
    host.start_cond();
    host.xfer({ADDR, 1'b0}, 1'b1, r, acc);
    host.xfer(ptr, 1'b1, r, nack);
    acc = acc | nack;
    for (int j = 0; j < n; j++) begin
      host.xfer(v ^ 8'(j), 1'b1, r, nack);
      acc = acc | nack;
    end
    host.stop_cond();
    chk("write acks", 8'h00, {7'h00, acc});
  endtask : reg_write

  task automatic reg_read(input logic [7:0] ptr, input int n);
    logic acc;
    host.start_cond();
    host.xfer({ADDR, 1'b0}, 1'b1, r, acc);
    host.xfer(ptr, 1'b1, r, nack);
    acc = acc | nack;
    host.start_cond();
    host.xfer({ADDR, 1'b1}, 1'b1, r, nack);
    acc = acc | nack;
    for (int j = 0; j < n; j++) begin
      host.xfer(8'hff, j == n - 1, got[j], nack);
    end
    host.stop_cond();
    chk("read acks", 8'h00, {7'h00, acc});
  endtask : reg_read

  task automatic check_fields(input logic [7:0] v);
    chk("speed fields", v, {stationary_judge_threshold, post_sense_advance_angle, initial_speed_detect_enable,
      reverse_drive_enable, reverse_threshold});
    chk("current fields", v ^ 8'h01, {open_loop_current, open_loop_ramp_rate, braking_time});
    chk("brake enable", {7'h00, (v[2:0] ^ 3'h1) != 3'h0}, {7'h00, braking_enable});
    chk("accel fields", v ^ 8'h02, {control_coefficient, start_accel_second_order, start_accel_first_order});
    chk("handover fields", v ^ 8'h03, {loop_handover_threshold, alignment_duration});
    chk("handover invalid", {7'h00, v[7:3] == 5'h00}, {7'h00, handover_code_invalid});
    chk("fault fields", v ^ 8'h04, {no_motor_fault_enable, lock_fault_enables, inductive_surge_enable,
      mechanical_surge_enable, mechanical_surge_mode, sense_release_mode});
  endtask : check_fields

  task automatic check_cleared();
    reg_read(OFS_SPEED_DETECT_REVERSE, 5);
    for (int i = 0; i < 5; i++) chk("reset value", 8'h00, got[i]);
    chk("reset invalid flag", 8'h01, {7'h00, handover_code_invalid});
  endtask : check_cleared

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial begin
    do_reset();
    check_cleared();
    // Eight patterns put every code into every field except the 5-bit handover threshold, which gets 8 of its 32
    for (int k = 0; k < 8; k++) begin
      b = {k[1:0], k[2:0], k[2:0]};
      reg_write(OFS_SPEED_DETECT_REVERSE, b, 5);
      check_fields(b);
      reg_read(OFS_SPEED_DETECT_REVERSE, 5);
      for (int i = 0; i < 5; i++) chk("readback", b ^ 8'(i), got[i]);
    end
    // Bursts straddling the lower and upper edges of the bank
    reg_write(8'h22, 8'h3c, 2);
    reg_read(8'h22, 2);
    chk("below bank", 8'h00, got[0]);
    chk("first register", 8'h3d, got[1]);
    reg_read(OFS_FAULT_SURGE_ENABLE, 2);
    chk("last register", 8'hfb, got[0]);
    chk("above bank", 8'h00, got[1]);
    // Foreign address must be ignored entirely
    host.start_cond();
    host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, r, nack);
    chk("foreign nack", 8'h01, {7'h00, nack});
    host.xfer(OFS_OPENLOOP_CURRENT_BRAKE, 1'b1, r, nack);
    host.xfer(8'h00, 1'b1, r, nack);
    host.stop_cond();
    reg_read(OFS_OPENLOOP_CURRENT_BRAKE, 1);
    chk("foreign write", 8'hfe, got[0]);
    do_reset();
    check_cleared();
    conclude();
  end
endmodule : tb
